// *** design/swd_top.sv ***
/*
  Software watchdog timer: 24-bit down counter kept alive by a two-write
  key sequence, control and timing count register, live count readback,
  sticky interrupt status with mask, and a timeout reset output.
  Assumes a single-cycle register port with read data one cycle later.
*/
`timescale 1ns/1ns
module swd_top
  import swd_pkg::*;
#(
  parameter int RST_PULSE = RST_PULSE_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [swd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [swd_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [swd_pkg::DATA_W-1:0] rdata_o,
  // interrupt and system reset request
  output logic irq_o,
  output logic wdog_reset_o
);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // control state
  logic wdog_enable_bit;
  logic wdog_lock_bit;
  logic [COUNT_W-1:0] timeout_reload_count;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;

  // reset pulse stretch
  logic [RST_CNT_W-1:0] rst_left;
  logic [RST_CNT_W-1:0] next_rst_left;

  // interrupt state
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] irq_mask;
  logic [EVT_W-1:0] event_pulse;

  // register decode
  logic ctrl_wr;
  logic service_wr;
  logic mask_wr;
  logic status_rd;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] ctrl_view;
  logic [DATA_W-1:0] count_view;
  logic [DATA_W-1:0] status_view;
  logic [DATA_W-1:0] mask_view;
  logic [DATA_W-1:0] key_view;

  // key sequence results
  logic service_hit;
  logic bad_key;
  logic key_armed;

  // counter events
  logic fire;
  logic locked_wr;

  // the service address doubles as the count register; every write there
  // is a key write, so no write path reaches the counter itself
  assign ctrl_wr = wr_i && hit(addr_i, ADDR_CONTROL);
  assign service_wr = wr_i && hit(addr_i, ADDR_SERVICE);
  assign mask_wr = wr_i && hit(addr_i, ADDR_IRQ_MASK);
  assign status_rd = rd_i && hit(addr_i, ADDR_IRQ_STATUS);
  assign locked_wr = ctrl_wr && wdog_lock_bit;

  swd_key_seq u_key_seq
  (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .key_wr_i(service_wr),
    .key_i(wdata_i[KEY_W-1:0]),
    .service_o(service_hit),
    .bad_key_o(bad_key),
    .armed_o(key_armed)
  );

  // a loaded zero wraps through all ones before reaching one again, so it
  // gives the full 2^24-cycle period instead of an instant timeout
  assign fire = wdog_enable_bit && (count == COUNT_ONE);

  always_comb
  begin
    next_count = count;
    if (service_hit || fire)
      next_count = timeout_reload_count;
    else if (wdog_enable_bit)
      next_count = count - COUNT_ONE;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      count <= COUNT_RESET;
    else
      count <= next_count;
  end

  // control register: lock bit blocks all three fields, itself included,
  // so once set it only falls with the system reset
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wdog_enable_bit <= ENABLE_RESET;
      wdog_lock_bit <= LOCK_RESET;
      timeout_reload_count <= COUNT_RESET;
    end
    else if (ctrl_wr && !wdog_lock_bit)
    begin
      wdog_enable_bit <= wdata_i[ENABLE_BIT];
      wdog_lock_bit <= wdata_i[LOCK_BIT];
      timeout_reload_count <= wdata_i[COUNT_LSB +: COUNT_W];
    end
  end

  // timeout reset pulse: a fresh timeout during a pulse restarts it
  always_comb
  begin
    next_rst_left = rst_left;
    if (fire)
      next_rst_left = RST_PULSE[RST_CNT_W-1:0];
    else if (rst_left != '0)
      next_rst_left = rst_left - {{(RST_CNT_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rst_left <= '0;
      wdog_reset_o <= 1'b0;
    end
    else
    begin
      rst_left <= next_rst_left;
      wdog_reset_o <= (next_rst_left != '0);
    end
  end

  // interrupt events
  assign event_pulse[EVT_TIMEOUT] = fire;
  assign event_pulse[EVT_SERVICE] = service_hit;
  assign event_pulse[EVT_BAD_KEY] = bad_key;
  assign event_pulse[EVT_LOCKED_WR] = locked_wr;

  // sticky bits: a set in the cycle of the clearing read wins
  genvar g;
  generate
    for (g = 0; g < EVT_W; g++)
    begin : g_sticky
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          irq_status[g] <= 1'b0;
        else if (event_pulse[g])
          irq_status[g] <= 1'b1;
        else if (status_rd)
          irq_status[g] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      irq_mask <= '0;
    else if (mask_wr)
      irq_mask <= wdata_i[EVT_W-1:0];
  end

  assign irq_o = |(irq_status & irq_mask);

  // read views, unused bits zero
  assign ctrl_view = {{(DATA_W-ENABLE_BIT-1){1'b0}}, wdog_enable_bit, wdog_lock_bit,
                      timeout_reload_count};
  assign count_view = {{(DATA_W-COUNT_W){1'b0}}, count};
  assign status_view = {{(DATA_W-EVT_W){1'b0}}, irq_status};
  assign mask_view = {{(DATA_W-EVT_W){1'b0}}, irq_mask};
  assign key_view = {{(DATA_W-1){1'b0}}, key_armed};

  always_comb
  begin
    next_rdata = READ_ZERO;
    if (hit(addr_i, ADDR_CONTROL))
      next_rdata = ctrl_view;
    else if (hit(addr_i, ADDR_COUNT))
      next_rdata = count_view;
    else if (hit(addr_i, ADDR_IRQ_STATUS))
      next_rdata = status_view;
    else if (hit(addr_i, ADDR_IRQ_MASK))
      next_rdata = mask_view;
    else if (hit(addr_i, ADDR_KEY_STATE))
      next_rdata = key_view;
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rdata_o <= READ_ZERO;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= READ_ZERO;
  end

endmodule

// *** design/swd_pkg.sv ***
/*
  Constants, register map and types of the software watchdog timer.
  Assumes a 50 MHz system clock and a simple word-wide register port.
*/
// Notes on behaviour
// - a service is the first key write followed directly by the second key write.
// - any other value written to the service register restarts the key sequence.
// - a completed service reloads the down counter from the timing count.
// - an unserviced watchdog whose period runs out raises a system reset.
// - the enable bit gates the down counter; it is set after reset.
// - while the lock bit is set, writes to lock, enable and count are ignored.
// - the timing count is 24 bits; the counter drops once per clock.
// - a timing count of zero gives the longest timeout, a full 24-bit wrap.
// - the count register reads the live counter in its low 24 bits.
// - writes aimed at the count register are key writes; they never load the counter directly.
// - control bits outside enable, lock and timing count read as zero.
package swd_pkg;

  // register port
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam logic [31:0] ADDR_CONTROL = 32'h8007_efc4;
  localparam logic [31:0] ADDR_SERVICE = 32'h8007_efc8;
  localparam logic [31:0] ADDR_COUNT = 32'h8007_efc8;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h8007_efb0;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h8007_efb4;
  localparam logic [31:0] ADDR_KEY_STATE = 32'h8007_efb8;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // control register layout (bit 0 of the printed layout is the msb)
  localparam int COUNT_W = 24;
  localparam int COUNT_LSB = 0;
  localparam int LOCK_BIT = 24;
  localparam int ENABLE_BIT = 25;
  localparam logic [23:0] COUNT_RESET = 24'hff_ffff;
  localparam logic [23:0] COUNT_ONE = 24'h00_0001;
  localparam logic ENABLE_RESET = 1'b1;
  localparam logic LOCK_RESET = 1'b0;

  // service keys sit in the low half of the written word
  localparam int KEY_W = 16;
  localparam logic [15:0] KEY_FIRST = 16'h556c;
  localparam logic [15:0] KEY_SECOND = 16'haa39;

  // interrupt events
  localparam int EVT_W = 4;
  localparam int EVT_TIMEOUT = 0;
  localparam int EVT_SERVICE = 1;
  localparam int EVT_BAD_KEY = 2;
  localparam int EVT_LOCKED_WR = 3;

  // length of the reset pulse driven out on a timeout
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_PULSE_NS = 320;
  localparam int RST_PULSE_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 8;

  typedef enum logic [1:0]
  {
    SWD_KEY_IDLE = 2'b01,
    SWD_KEY_ARMED = 2'b10
  } swd_key_state_t;

endpackage

// *** design/swd_key_seq.sv ***
/*
  Service key sequence recogniser of the software watchdog.
  Assumes one-cycle write strobes already decoded to the service address.
*/
`timescale 1ns/1ns
module swd_key_seq
  import swd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // service register writes
  input wire logic key_wr_i,
  input wire logic [swd_pkg::KEY_W-1:0] key_i,
  // results
  output logic service_o,
  output logic bad_key_o,
  output logic armed_o
);
  swd_key_state_t state;
  swd_key_state_t next_state;
  logic is_first;
  logic is_second;

  assign is_first = (key_i == KEY_FIRST);
  assign is_second = (key_i == KEY_SECOND);
  assign armed_o = (state == SWD_KEY_ARMED);

  always_comb
  begin
    next_state = state;
    service_o = 1'b0;
    bad_key_o = 1'b0;
    if (key_wr_i)
    begin
      case (state)
        SWD_KEY_IDLE:
        begin
          // a lone second key is a key value, so it is not an error
          if (is_first)
            next_state = SWD_KEY_ARMED;
          else if (!is_second)
            bad_key_o = 1'b1;
        end
        SWD_KEY_ARMED:
        begin
          if (is_second)
          begin
            service_o = 1'b1;
            next_state = SWD_KEY_IDLE;
          end
          else if (!is_first)
          begin
            bad_key_o = 1'b1;
            next_state = SWD_KEY_IDLE;
          end
        end
        default:
          next_state = SWD_KEY_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      state <= SWD_KEY_IDLE;
    else
      state <= next_state;
  end

endmodule

// *** bench/swd_asserts.sv ***
/*
  Port checker for the software watchdog top.
  Assumes it is bound onto swd_top and sees only its ports.
*/
`timescale 1ns/1ns
module swd_asserts
  import swd_pkg::*;
#(
  parameter int RST_PULSE = 16
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register port
  input wire logic [swd_pkg::ADDR_W-1:0] addr_i,
  input wire logic [swd_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [swd_pkg::DATA_W-1:0] rdata_o,
  // outputs
  input wire logic irq_o,
  input wire logic wdog_reset_o
);
  import swd_pkg::*;
  logic en_m;
  logic lock_m;
  logic [23:0] tc_m;
  logic [7:0] hi_run;
  wire ctrl_wr = wr_i && addr_i == ADDR_CONTROL && !lock_m;
  wire rd_cnt = rd_i && addr_i == ADDR_COUNT;
  // control model; writes while locked are dropped
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      en_m <= ENABLE_RESET;
      lock_m <= LOCK_RESET;
      tc_m <= COUNT_RESET;
    end
    else if (ctrl_wr)
    begin
      en_m <= wdata_i[ENABLE_BIT];
      lock_m <= wdata_i[LOCK_BIT];
      tc_m <= wdata_i[23:0];
    end
  end
  always_ff @(posedge clk_i)
  begin
    hi_run <= (srst_i || !wdog_reset_o) ? 8'h00 : hi_run + 8'h01;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence key_pair;
    wr_i && addr_i == ADDR_SERVICE && wdata_i[15:0] == KEY_FIRST
    ##1 wr_i && addr_i == ADDR_SERVICE && wdata_i[15:0] == KEY_SECOND;
  endsequence
  svc_reload_a: assert property (key_pair ##1 rd_cnt |=> rdata_o == {8'h00, tc_m})
    else $error("count not reloaded by service");
  ctrl_read_a: assert property (rd_i && addr_i == ADDR_CONTROL |=>
    rdata_o == {6'h00, en_m, lock_m, tc_m}) else $error("control readback wrong");
  count_upper_a: assert property (rd_cnt |=> rdata_o[31:24] == 8'h00)
    else $error("count upper bits set");
  fire_enabled_a: assert property ($rose(wdog_reset_o) |-> $past(en_m))
    else $error("reset fired while disabled");
  pulse_len_a: assert property ($fell(wdog_reset_o) |-> hi_run == RST_PULSE)
    else $error("reset pulse length wrong");
  rdata_idle_a: assert property (!rd_i |=> rdata_o == READ_ZERO)
    else $error("read data outside read cycle");
  reset_quiet_a: assert property ($fell(srst_i) |-> !wdog_reset_o && !irq_o)
    else $error("outputs active after reset");
  status_upper_a: assert property (rd_i && addr_i == ADDR_IRQ_STATUS |=>
    rdata_o[31:4] == 28'h000_0000) else $error("status upper bits set");
endmodule

bind swd_top swd_asserts #(.RST_PULSE(RST_PULSE)) u_swd_asserts (.clk_i(clk_i),
  .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .wdog_reset_o(wdog_reset_o));

// *** bench/tb.sv ***
/*
  Self-checking bench for the software watchdog top.
  Assumes the register port of swd_pkg and a short reset pulse.
*/
`timescale 1ns/1ns
module tb;
  import swd_pkg::*;
  localparam int PULSE = 4;
  localparam logic [31:0] K1 = {16'h0000, KEY_FIRST};
  localparam logic [31:0] K2 = {16'h0000, KEY_SECOND};
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [31:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o;
  logic wdog_reset_o;
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  swd_top #(.RST_PULSE(PULSE)) u_swd_top (.clk_i(clk_i), .srst_i(srst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .wdog_reset_o(wdog_reset_o));
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input logic w, input logic r, input logic [31:0] a, input logic [31:0] d);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
  endtask
  task automatic w(input logic [31:0] a, input logic [31:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  // data stands one cycle after the strobe edge, so look just after it
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    op(1'b0, 1'b1, a, '0);
    #1;
    chk(rdata_o, exp);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    mismatches++;
    conclude();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(ADDR_CONTROL, 32'h02ff_ffff);
    rd(ADDR_IRQ_MASK, 32'h0000_0000);
    w(32'h8007_efcc, 32'hffff_ffff);
    rd(32'h8007_efcc, 32'h0000_0000);
    // counter frozen so reload values read back exactly
    w(ADDR_CONTROL, 32'h0000_0100);
    w(ADDR_SERVICE, 32'hffff_556c);
    w(ADDR_SERVICE, K2);
    rd(ADDR_COUNT, 32'h0000_0100);
    w(ADDR_CONTROL, 32'h0000_0050);
    w(ADDR_SERVICE, K2);
    w(ADDR_SERVICE, K1);
    rd(ADDR_KEY_STATE, 32'h0000_0001);
    w(ADDR_SERVICE, 32'h0000_1234);
    rd(ADDR_KEY_STATE, 32'h0000_0000);
    w(ADDR_SERVICE, K2);
    rd(ADDR_COUNT, 32'h0000_0100);
    rd(ADDR_IRQ_STATUS, 32'h0000_0006);
    rd(ADDR_IRQ_STATUS, 32'h0000_0000);
    w(ADDR_SERVICE, 32'h0000_0000);
    #1 chk({31'h0, irq_o}, 32'h0000_0000);
    w(ADDR_IRQ_MASK, 32'h0000_0004);
    #1 chk({31'h0, irq_o}, 32'h0000_0001);
    rd(ADDR_IRQ_STATUS, 32'h0000_0004);
    chk({31'h0, irq_o}, 32'h0000_0000);
    // timeout period and pulse
    w(ADDR_IRQ_MASK, 32'h0000_000f);
    w(ADDR_CONTROL, 32'h0200_0020);
    w(ADDR_SERVICE, K1);
    w(ADDR_SERVICE, K2);
    n = 0;
    while (wdog_reset_o !== 1'b1 && n < 100)
    begin
      op(1'b0, 1'b0, '0, '0);
      #1 n++;
    end
    chk(n, 32'h0000_0020);
    n = 0;
    while (wdog_reset_o === 1'b1 && n < 100)
    begin
      op(1'b0, 1'b0, '0, '0);
      #1 n++;
    end
    chk(n, PULSE);
    w(ADDR_CONTROL, 32'h0000_0020);
    #1 chk({31'h0, irq_o}, 32'h0000_0001);
    rd(ADDR_IRQ_STATUS, 32'h0000_0003);
    // zero count reloads zero, then wraps on the first enabled cycle
    w(ADDR_CONTROL, 32'h0000_0000);
    w(ADDR_SERVICE, K1);
    w(ADDR_SERVICE, K2);
    rd(ADDR_COUNT, 32'h0000_0000);
    w(ADDR_CONTROL, 32'h0200_0000);
    op(1'b0, 1'b0, '0, '0);
    rd(ADDR_COUNT, 32'h00ff_ffff);
    rd(ADDR_IRQ_STATUS, 32'h0000_0002);
    w(ADDR_CONTROL, 32'h0100_0010);
    w(ADDR_CONTROL, 32'h0200_0077);
    rd(ADDR_CONTROL, 32'h0100_0010);
    rd(ADDR_IRQ_STATUS, 32'h0000_0008);
    srst_i <= 1'b1;
    repeat (2) op(1'b0, 1'b0, '0, '0);
    srst_i <= 1'b0;
    rd(ADDR_CONTROL, 32'h02ff_ffff);
    conclude();
  end
endmodule
